// ---- hw/skip_test_map.vh ----
`ifndef SKIP_TEST_MAP_VH
`define SKIP_TEST_MAP_VH

// instruction codes, ten bits
`define OP_SKIP_ACC_EQ_MEM      10'h026
`define OP_SKIP_EXT0_FLAG_SET   10'h038
`define OP_SKIP_CONV_DONE       10'h287
`define OP_SKIP_EXT_PIN_LEVEL   10'h03a

// control bit positions
`define EXT0_IRQ_ENABLE_BIT     0
`define CONV_IRQ_ENABLE_BIT     2
`define PIN_POLARITY_BIT        2

// register byte offsets
`define REG_IRQ_CTRL_FIRST      8'h00
`define REG_IRQ_CTRL_SECOND     8'h04
`define REG_PIN_IRQ_CTRL        8'h08
`define REG_FLAG_VIEW           8'h0c
`define REG_EVENT_STATUS        8'h10
`define REG_EVENT_MASK          8'h14

// flag view bits
`define VIEW_EXT0_FLAG_BIT      0
`define VIEW_CONV_FLAG_BIT      1
`define VIEW_PIN_LEVEL_BIT      2
`define VIEW_SKIP_ACTIVE_BIT    3

// event status bits
`define EVT_SKIP_ARMED_BIT      0
`define EVT_EXT0_CLEARED_BIT    1
`define EVT_CONV_CLEARED_BIT    2
`define EVT_DISCARDED_BIT       3

// widths and reset values
`define CTRL_WIDTH              4
`define EVT_WIDTH               4
`define ADDR_DECODE_WIDTH       8
`define CTRL_RESET              4'h0
`define EVT_RESET               4'h0
`define FLAG_RESET              1'b0
`define DATA_RESET              32'h0000_0000
`define HTRANS_NONSEQ_BIT       1
`define HRESP_OKAY              1'b0

// request flag cells
`define FLAG_COUNT              2
`define FLAG_EXT0_IDX           0
`define FLAG_CONV_IDX           1

`endif

// ---- hw/request_flag_cell.v ----
`timescale 1ns/1ns
`default_nettype none
`include "skip_test_map.vh"

module request_flag_cell (
   // clock and reset
   input  wire hclk,
   input  wire hresetn,
   // flag control
   input  wire set_pulse,
   input  wire clear_pulse,
   output reg  flag_reg
);

   // a source event in the clearing cycle must not be lost
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_reg <= `FLAG_RESET;
      end else if (set_pulse) begin
         flag_reg <= 1'b1;
      end else if (clear_pulse) begin
         flag_reg <= 1'b0;
      end
   end

endmodule // request_flag_cell
`default_nettype wire

// ---- hw/skip_test_instruction_logic.v ----
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "skip_test_map.vh"

module skip_test_instruction_logic #(
   parameter INSTR_WIDTH = 10,
   parameter DATA_WIDTH  = 4
) (
   // clock and reset
   input  wire                   hclk,
   input  wire                   hresetn,
   // ahb-lite slave
   input  wire                   hsel,
   input  wire [31:0]            haddr,
   input  wire [1:0]             htrans,
   input  wire                   hwrite,
   input  wire [2:0]             hsize,
   input  wire [31:0]            hwdata,
   input  wire                   hready,
   output reg  [31:0]            hrdata,
   output reg                    hreadyout,
   output reg                    hresp,
   // instruction stream from fetch
   input  wire                   instr_valid,
   input  wire [INSTR_WIDTH-1:0] instr_word,
   // core operands
   input  wire [DATA_WIDTH-1:0]  accumulator,
   input  wire [DATA_WIDTH-1:0]  pointed_memory_word,
   // flag sources and pin
   input  wire                   ext0_event,
   input  wire                   conv_event,
   input  wire                   ext_pin_level,
   // results to the core
   output reg                    skip_active,
   output reg                    test_executed,
   output wire                   ext0_request_flag,
   output wire                   conv_done_flag,
   // interrupt
   output reg                    irq
);

   // ------------------------------------------------------------------
   // control registers
   reg  [`CTRL_WIDTH-1:0] irq_ctrl_first_reg;
   reg  [`CTRL_WIDTH-1:0] irq_ctrl_second_reg;
   reg  [`CTRL_WIDTH-1:0] pin_irq_ctrl_reg;
   reg  [`EVT_WIDTH-1:0]  status_reg;
   reg  [`EVT_WIDTH-1:0]  status_next;
   reg  [`EVT_WIDTH-1:0]  mask_reg;
   reg  [`EVT_WIDTH-1:0]  mask_next;
   reg                    skip_pending_reg;
   reg                    skip_pending_next;

   // bus phase capture
   reg                            wr_pending_reg;
   reg  [`ADDR_DECODE_WIDTH-1:0]  wr_addr_reg;
   reg  [31:0]                    read_mux;

   // decode
   wire ext0_irq_enable;
   wire conv_irq_enable;
   wire pin_polarity_select;
   wire execute;
   wire discard;
   wire is_acc_eq_mem;
   wire is_ext0_test;
   wire is_conv_test;
   wire is_pin_test;
   wire ext0_gate_open;
   wire conv_gate_open;
   wire skip_acc_eq_mem;
   wire skip_ext0_flag_set;
   wire skip_conv_done;
   wire skip_ext_pin_level;
   wire skip_next;
   wire ext0_clear;
   wire conv_clear;
   wire bus_access;
   wire bus_read;
   wire bus_write;
   wire status_read;
   wire [`ADDR_DECODE_WIDTH-1:0] addr_lo;
   wire [`EVT_WIDTH-1:0]         events;
   wire                          any_test;
   // per-flag cell wiring
   wire [`FLAG_COUNT-1:0]        flag_set;
   wire [`FLAG_COUNT-1:0]        flag_clear;
   wire [`FLAG_COUNT-1:0]        flag_q;
   genvar                        flag_idx;

   assign ext0_irq_enable     = irq_ctrl_first_reg[`EXT0_IRQ_ENABLE_BIT];
   assign conv_irq_enable     = irq_ctrl_second_reg[`CONV_IRQ_ENABLE_BIT];
   assign pin_polarity_select = pin_irq_ctrl_reg[`PIN_POLARITY_BIT];

   // ------------------------------------------------------------------
   // instruction decode
   // a word arriving while a skip is pending is the skipped one
   assign discard = instr_valid & skip_pending_reg;
   assign execute = instr_valid & ~skip_pending_reg;

   // exact ten-bit match; each test is a single word, single cycle
   assign is_acc_eq_mem = execute & (instr_word == `OP_SKIP_ACC_EQ_MEM);
   assign is_ext0_test  = execute & (instr_word == `OP_SKIP_EXT0_FLAG_SET);
   assign is_conv_test  = execute & (instr_word == `OP_SKIP_CONV_DONE);
   assign is_pin_test   = execute & (instr_word == `OP_SKIP_EXT_PIN_LEVEL);

   // enable bit set turns the flag tests into a no-operation
   assign ext0_gate_open = is_ext0_test & ~ext0_irq_enable;
   assign conv_gate_open = is_conv_test & ~conv_irq_enable;

   // ------------------------------------------------------------------
   // skip conditions
   assign skip_acc_eq_mem    = is_acc_eq_mem & (accumulator == pointed_memory_word);
   assign skip_ext0_flag_set = ext0_gate_open & ext0_request_flag;
   assign skip_conv_done     = conv_gate_open & conv_done_flag;
   // pin is taken as synchronous; no synchroniser here
   // low level skips with polarity 0, high level with polarity 1
   assign skip_ext_pin_level = is_pin_test & (ext_pin_level == pin_polarity_select);

   assign skip_next = skip_acc_eq_mem | skip_ext0_flag_set | skip_conv_done |
                      skip_ext_pin_level;

   // clear happens whether or not the flag was set
   assign ext0_clear = ext0_gate_open;
   assign conv_clear = conv_gate_open;

   // a discarded word cannot arm a new skip: execute excludes it
   always @* begin
      skip_pending_next = skip_pending_reg;
      if (skip_next) begin
         skip_pending_next = 1'b1;
      end else if (discard) begin
         skip_pending_next = 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         skip_pending_reg <= 1'b0;
      end else begin
         skip_pending_reg <= skip_pending_next;
      end
   end

   // all four tests report, a gated one as a no-operation too
   assign any_test = is_acc_eq_mem | is_ext0_test | is_conv_test | is_pin_test;

   // carry is never driven from here, so every test leaves it alone
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         skip_active   <= 1'b0;
         test_executed <= 1'b0;
      end else begin
         skip_active   <= skip_pending_next;
         test_executed <= any_test;
      end
   end

   // ------------------------------------------------------------------
   // request flags, one cell per flag; a set in the clearing cycle wins
   assign flag_set[`FLAG_EXT0_IDX]   = ext0_event;
   assign flag_set[`FLAG_CONV_IDX]   = conv_event;
   assign flag_clear[`FLAG_EXT0_IDX] = ext0_clear;
   assign flag_clear[`FLAG_CONV_IDX] = conv_clear;

   generate
      for (flag_idx = 0; flag_idx < `FLAG_COUNT; flag_idx = flag_idx + 1) begin : g_flag
         request_flag_cell flag_cell (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .set_pulse   (flag_set[flag_idx]),
            .clear_pulse (flag_clear[flag_idx]),
            .flag_reg    (flag_q[flag_idx])
         );
      end
   endgenerate

   assign ext0_request_flag = flag_q[`FLAG_EXT0_IDX];
   assign conv_done_flag    = flag_q[`FLAG_CONV_IDX];

   // ------------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // hsize is not decoded: every register is one aligned word
   assign bus_access = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
   assign bus_read   = bus_access & ~hwrite;
   assign bus_write  = bus_access & hwrite;
   assign addr_lo    = haddr[`ADDR_DECODE_WIDTH-1:0];
   assign status_read = bus_read & (addr_lo == `REG_EVENT_STATUS);

   // read data is sampled at the address phase so it stands in a flop
   always @* begin
      read_mux = `DATA_RESET;
      case (addr_lo)
         `REG_IRQ_CTRL_FIRST: begin
            read_mux[`CTRL_WIDTH-1:0] = irq_ctrl_first_reg;
         end
         `REG_IRQ_CTRL_SECOND: begin
            read_mux[`CTRL_WIDTH-1:0] = irq_ctrl_second_reg;
         end
         `REG_PIN_IRQ_CTRL: begin
            read_mux[`CTRL_WIDTH-1:0] = pin_irq_ctrl_reg;
         end
         `REG_FLAG_VIEW: begin
            read_mux[`VIEW_EXT0_FLAG_BIT]   = ext0_request_flag;
            read_mux[`VIEW_CONV_FLAG_BIT]   = conv_done_flag;
            read_mux[`VIEW_PIN_LEVEL_BIT]   = ext_pin_level;
            read_mux[`VIEW_SKIP_ACTIVE_BIT] = skip_pending_reg;
         end
         `REG_EVENT_STATUS: begin
            read_mux[`EVT_WIDTH-1:0] = status_reg;
         end
         `REG_EVENT_MASK: begin
            read_mux[`EVT_WIDTH-1:0] = mask_reg;
         end
         default: begin
            read_mux = `DATA_RESET;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= `DATA_RESET;
         hreadyout <= 1'b1;
         hresp     <= `HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= `HRESP_OKAY;
         if (bus_read) begin
            hrdata <= read_mux;
         end
      end
   end

   // writes land in the data phase, when hwdata is valid
   // write address held until the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending_reg <= 1'b0;
         wr_addr_reg    <= {`ADDR_DECODE_WIDTH{1'b0}};
      end else begin
         wr_pending_reg <= bus_write;
         if (bus_write) begin
            wr_addr_reg <= addr_lo;
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ctrl_first_reg  <= `CTRL_RESET;
         irq_ctrl_second_reg <= `CTRL_RESET;
         pin_irq_ctrl_reg    <= `CTRL_RESET;
      end else if (wr_pending_reg) begin
         case (wr_addr_reg)
            `REG_IRQ_CTRL_FIRST: begin
               irq_ctrl_first_reg <= hwdata[`CTRL_WIDTH-1:0];
            end
            `REG_IRQ_CTRL_SECOND: begin
               irq_ctrl_second_reg <= hwdata[`CTRL_WIDTH-1:0];
            end
            `REG_PIN_IRQ_CTRL: begin
               pin_irq_ctrl_reg <= hwdata[`CTRL_WIDTH-1:0];
            end
            default: begin
               pin_irq_ctrl_reg <= pin_irq_ctrl_reg;
            end
         endcase
      end
   end

   // the mask's next value lets irq follow a mask write at the same edge
   always @* begin
      mask_next = mask_reg;
      if (wr_pending_reg && (wr_addr_reg == `REG_EVENT_MASK)) begin
         mask_next = hwdata[`EVT_WIDTH-1:0];
      end
   end

   // ------------------------------------------------------------------
   // sticky events, cleared by reading; a new event beats the read clear
   assign events[`EVT_SKIP_ARMED_BIT]   = skip_next;
   assign events[`EVT_EXT0_CLEARED_BIT] = ext0_clear & ext0_request_flag;
   assign events[`EVT_CONV_CLEARED_BIT] = conv_clear & conv_done_flag;
   assign events[`EVT_DISCARDED_BIT]    = discard;

   always @* begin
      status_next = status_reg;
      if (status_read) begin
         status_next = `EVT_RESET;
      end
      status_next = status_next | events;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= `EVT_RESET;
         mask_reg   <= `EVT_RESET;
         irq        <= 1'b0;
      end else begin
         // irq uses next status and mask so it never lags either
         status_reg <= status_next;
         mask_reg   <= mask_next;
         irq        <= |(status_next & mask_next);
      end
   end

endmodule // skip_test_instruction_logic
`default_nettype wire

// ---- dv/skip_test_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "skip_test_map.vh"
module skip_test_sva #(
   parameter INSTR_WIDTH = 10,
   parameter DATA_WIDTH  = 4
) (
   // clock and reset
   input wire logic                   hclk,
   input wire logic                   hresetn,
   // instruction side
   input wire logic                   instr_valid,
   input wire logic [INSTR_WIDTH-1:0] instr_word,
   input wire logic [DATA_WIDTH-1:0]  accumulator,
   input wire logic [DATA_WIDTH-1:0]  pointed_memory_word,
   input wire logic                   ext0_event,
   // results
   input wire logic                   skip_active,
   input wire logic                   test_executed,
   input wire logic                   ext0_request_flag,
   input wire logic                   conv_done_flag
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire live     = instr_valid && !skip_active;
   wire ext0_try = live && instr_word == `OP_SKIP_EXT0_FLAG_SET;
   wire conv_try = live && instr_word == `OP_SKIP_CONV_DONE;
   sequence s_eq_test;
      live && instr_word == `OP_SKIP_ACC_EQ_MEM;
   endsequence
   sequence s_eq_hit;
      s_eq_test ##0 accumulator == pointed_memory_word;
   endsequence
   a_eq_arms: assert property (s_eq_hit |=> skip_active && test_executed)
      else $error("equal operands did not arm a skip");
   a_eq_miss: assert property (s_eq_test ##0 accumulator != pointed_memory_word |=> !skip_active)
      else $error("unequal operands armed a skip");
   a_discard_once: assert property (instr_valid && skip_active |=> !skip_active)
      else $error("skipped instruction armed another skip");
   a_skip_holds: assert property (skip_active && !instr_valid |=> skip_active)
      else $error("pending skip dropped without an instruction");
   a_ext0_quiet: assert property (ext0_try && !ext0_request_flag |=> !skip_active)
      else $error("flag test skipped on a clear flag");
   a_conv_quiet: assert property (conv_try && !conv_done_flag |=> !skip_active)
      else $error("completion test skipped on a clear flag");
   a_ext0_clear_src: assert property ($fell(ext0_request_flag) |-> $past(ext0_try))
      else $error("request flag cleared without its test");
   a_conv_clear_src: assert property ($fell(conv_done_flag) |-> $past(conv_try))
      else $error("done flag cleared without its test");
   a_event_sets: assert property (ext0_event |=> ext0_request_flag)
      else $error("event lost against a clear");
   a_pin_runs: assert property (live && instr_word == `OP_SKIP_EXT_PIN_LEVEL |=> test_executed)
      else $error("pin test not reported as executed");
endmodule // skip_test_sva
bind skip_test_instruction_logic skip_test_sva #(
   .INSTR_WIDTH(INSTR_WIDTH),
   .DATA_WIDTH(DATA_WIDTH)
) chk (.hclk, .hresetn, .instr_valid, .instr_word, .accumulator, .pointed_memory_word,
   .ext0_event, .skip_active, .test_executed, .ext0_request_flag, .conv_done_flag);
`default_nettype wire

// ---- dv/skip_test_instruction_logic_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "skip_test_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module skip_test_instruction_logic_bench;
   typedef struct {string n; logic [31:0] e;} note_t;
   note_t       q[$];
   logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, instr_valid = 0, probe = 0;
   logic        ext0_event = 0, conv_event = 0, pin = 0, inst_d = 0, rd_d = 0;
   logic [31:0] haddr = 0, hwdata = 0, seed = 32'd1372, r;
   logic [1:0]  htrans = 0;
   logic [9:0]  word = 0, op = 0;
   logic [3:0]  acc = 0, mem = 0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, skip, te, f0, fc, irq;
   int          failures = 0, total_checks = 0, n, i;
   bit          en0, en2, pol, e0, cv, sk;
   bit   [3:0]  st, mk;
   skip_test_instruction_logic uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .instr_valid(instr_valid), .instr_word(word), .accumulator(acc),
      .pointed_memory_word(mem), .ext0_event(ext0_event), .conv_event(conv_event),
      .ext_pin_level(pin), .skip_active(skip), .test_executed(te),
      .ext0_request_flag(f0), .conv_done_flag(fc), .irq(irq));
   always #10 hclk = ~hclk;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task pop_cmp(input logic [31:0] g);
      note_t x;
      x = q.pop_front();
      `CHK(x.n, x.e, g)
   endtask
   // results surface one edge after the request that caused them
   always @(posedge hclk) begin
      inst_d <= instr_valid;
      rd_d <= hsel && hreadyout && htrans[1] && !hwrite;
      if (inst_d) pop_cmp({28'h0, te, skip, f0, fc});
      if (rd_d) pop_cmp(hrdata);
      if (probe) pop_cmp({31'h0, irq});
   end
   task tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task wait_rdy();
      n = 0;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin failures++; tally_and_finish(); end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      instr_valid <= 0;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back('{"hrdata", e});
      bus(0, a, 0);
   endtask
   task wr(input logic [7:0] a, input logic [3:0] d);
      bus(1, a, {28'h0, d});
      if (a == `REG_IRQ_CTRL_FIRST) en0 = d[0];
      if (a == `REG_IRQ_CTRL_SECOND) en2 = d[2];
      if (a == `REG_PIN_IRQ_CTRL) pol = d[2];
      if (a == `REG_EVENT_MASK) mk = d;
   endtask
   task rd_st();
      rd(`REG_EVENT_STATUS, {28'h0, st});
      st = 0;
   endtask
   task ev(input bit a, input bit b);
      instr_valid <= 0;
      ext0_event <= a;
      conv_event <= b;
      @(posedge hclk);
      ext0_event <= 0;
      conv_event <= 0;
      e0 |= a;
      cv |= b;
      @(posedge hclk);
   endtask
   task irq_is();
      instr_valid <= 0;
      repeat (2) @(posedge hclk);
      q.push_back('{"irq", {31'h0, |(st & mk)}});
      probe <= 1;
      @(posedge hclk);
      probe <= 0;
   endtask
   task ins(input logic [9:0] w, input logic [3:0] a, input logic [3:0] m, input logic p);
      bit s;
      bit t;
      s = 0;
      t = 0;
      instr_valid <= 1;
      word <= w;
      acc <= a;
      mem <= m;
      pin <= p;
      if (sk) st[3] = 1;
      else begin
         // every test reports execution, a gated one as a no-operation
         t = (w == `OP_SKIP_ACC_EQ_MEM) || (w == `OP_SKIP_EXT0_FLAG_SET) ||
             (w == `OP_SKIP_CONV_DONE) || (w == `OP_SKIP_EXT_PIN_LEVEL);
         case (w)
            `OP_SKIP_ACC_EQ_MEM: s = (a == m);
            `OP_SKIP_EXT0_FLAG_SET: if (!en0) begin s = e0; st[1] |= e0; e0 = 0; end
            `OP_SKIP_CONV_DONE: if (!en2) begin s = cv; st[2] |= cv; cv = 0; end
            `OP_SKIP_EXT_PIN_LEVEL: s = (p == pol);
            default: ;
         endcase
      end
      sk = s;
      st[0] |= s;
      q.push_back('{"skip_flags", {28'h0, t, sk, e0, cv}});
      @(posedge hclk);
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      rd(`REG_IRQ_CTRL_FIRST, 0);
      rd(8'h20, 0);
      wr(`REG_EVENT_MASK, 4'h0);
      ev(1, 1);
      rd(`REG_FLAG_VIEW, 32'h3);
      ins(`OP_SKIP_ACC_EQ_MEM, 4'h5, 4'h5, 0);
      ins(`OP_SKIP_EXT0_FLAG_SET, 0, 0, 0);
      ins(`OP_SKIP_ACC_EQ_MEM, 4'hf, 4'he, 0);
      ins(`OP_SKIP_EXT0_FLAG_SET, 0, 0, 0);
      ins(`OP_SKIP_CONV_DONE, 0, 0, 0);
      ins(`OP_SKIP_CONV_DONE, 0, 0, 0);
      ins(`OP_SKIP_EXT0_FLAG_SET, 0, 0, 0);
      ins(`OP_SKIP_CONV_DONE, 0, 0, 0);
      wr(`REG_IRQ_CTRL_FIRST, 4'h1);
      wr(`REG_IRQ_CTRL_SECOND, 4'h4);
      ev(1, 1);
      ins(`OP_SKIP_EXT0_FLAG_SET, 0, 0, 0);
      ins(`OP_SKIP_CONV_DONE, 0, 0, 0);
      wr(`REG_IRQ_CTRL_FIRST, 4'h0);
      wr(`REG_IRQ_CTRL_SECOND, 4'h0);
      for (i = 0; i < 4; i++) begin
         wr(`REG_PIN_IRQ_CTRL, {1'b0, i[1], 2'b0});
         ins(`OP_SKIP_EXT_PIN_LEVEL, 0, 1, i[0]);
         ins(10'h000, 0, 0, i[0]);
      end
      irq_is();
      wr(`REG_EVENT_MASK, 4'hf);
      irq_is();
      rd_st();
      irq_is();
      rd_st();
      // random mix keeps events off instruction edges to avoid set/clear races
      for (i = 0; i < 80; i++) begin
         r = rnd();
         if (r[0]) ev(r[1], r[2]);
         if (r[3]) wr(r[4] ? `REG_IRQ_CTRL_FIRST : `REG_IRQ_CTRL_SECOND, r[8:5]);
         case (r[10:8] % 5)
            0: op = `OP_SKIP_ACC_EQ_MEM;
            1: op = `OP_SKIP_EXT0_FLAG_SET;
            2: op = `OP_SKIP_CONV_DONE;
            3: op = `OP_SKIP_EXT_PIN_LEVEL;
            default: op = r[31:22];
         endcase
         ins(op, r[13:11], r[16:14], r[17]);
         if (r[18]) irq_is();
      end
      rd_st();
      irq_is();
      tally_and_finish();
   end
   initial begin
      #1000000;
      failures++;
      tally_and_finish();
   end
endmodule // skip_test_instruction_logic_bench
`default_nettype wire
